// ==== logic/bcr_cfg.svh ====
// Constants for the branch, call and return decoder.
// Assumes 16-bit instruction words: opcode 15-11, field 10-8, op 7-4, operand 3-0.
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH
`define BCR_OP_CALL 5'h1c
`define BCR_OP_SYS 5'h07
`define BCR_OP_JUMP_BASE 5'h0c
`define BCR_OP_JUMP_TOP 5'h0f
`define BCR_SUB_JUMP_IND 4'h4
`define BCR_SUB_CALL_IND 4'h5
`define BCR_SUB_SYSCALL 4'h0
`define BCR_SUB_RET 4'he
`define BCR_SUB_MISC 4'hf
`define BCR_F_RET 3'h0
`define BCR_F_RETSKIP 3'h1
`define BCR_F_INTERRUPT_RETURN 3'h4
`define BCR_F_IRQ_ALLOW 3'h0
`define BCR_F_IRQ_BLOCK 3'h1
`define BCR_F_STOP 3'h2
`define BCR_F_HALT 3'h3
`define BCR_F_NOP 3'h4
`define BCR_PC_W 13
`define BCR_SP_W 3
`define BCR_SP_RST 3'h0
`define BCR_PC_RST 13'h0000
`define BCR_SAVED_W 4
`define BCR_STACK_DEPTH 8
`define BCR_F_PLAIN 3'h0
`define BCR_OPND_NONE 4'h0
`define BCR_PAGE_ZERO 2'h0
`define BCR_SYS_MID 4'h0
`define BCR_SAVED_RST 4'h0
`define BCR_COND_RST 4'h0
`endif

// ==== logic/bcr_pkg.sv ====
// Types shared by the branch, call and return decoder.
// Assumes bcr_cfg.svh is on the include path.
`include "bcr_cfg.svh"
package bcr_pkg;
	typedef enum logic [3:0]
	{
		BCR_NONE = 4'h0,
		BCR_JUMP = 4'h1,
		BCR_JUMP_IND = 4'h3,
		BCR_CALL = 4'h2,
		BCR_CALL_IND = 4'h6,
		BCR_SYSCALL = 4'h7,
		BCR_RET = 4'h5,
		BCR_RETSKIP = 4'h4,
		BCR_INTERRUPT_RETURN = 4'hc,
		BCR_IRQ_ALLOW = 4'hd,
		BCR_IRQ_BLOCK = 4'hf,
		BCR_STOP = 4'he,
		BCR_HALT = 4'ha,
		BCR_NOP = 4'hb
	} bcr_op_t;
	typedef struct packed
	{
		bcr_op_t op;
		logic [1:0] page;
		logic [10:0] addr;
		logic [3:0] cond;
	} bcr_dec_t;
endpackage

// ==== logic/bcr_decode.sv ====
// Combinational instruction classifier for control-flow words.
// Assumes a full 16-bit instruction word and a variant selector.
`timescale 1ns/1ps
`include "bcr_cfg.svh"
module bcr_decode
	import bcr_pkg::*;
(
	input wire logic [15:0] instr,
	input wire logic smallRom,
	output bcr_dec_t dec
);
	wire [4:0] opc = instr[15:11];
	wire [2:0] fld = instr[10:8];
	wire [3:0] sub = instr[7:4];
	wire isSys = (opc == `BCR_OP_SYS);
	wire isJump = smallRom ? (opc == `BCR_OP_JUMP_BASE)
		: (opc >= `BCR_OP_JUMP_BASE && opc <= `BCR_OP_JUMP_TOP);
	wire isRetGrp = isSys && sub == `BCR_SUB_RET && instr[3:0] == `BCR_OPND_NONE;
	wire isMisc = isSys && sub == `BCR_SUB_MISC;
	bcr_op_t op;
	// Classify the word; unknown words fall through to none
	always_comb
	begin
		op = BCR_NONE;
		if (isJump)
			op = BCR_JUMP;
		else if (opc == `BCR_OP_CALL)
			op = BCR_CALL;
		else if (isSys && sub == `BCR_SUB_JUMP_IND && fld == `BCR_F_PLAIN)
			op = BCR_JUMP_IND;
		else if (isSys && sub == `BCR_SUB_CALL_IND && fld == `BCR_F_PLAIN)
			op = BCR_CALL_IND;
		else if (isSys && sub == `BCR_SUB_SYSCALL)
			op = BCR_SYSCALL;
		else if (isRetGrp && fld == `BCR_F_RET)
			op = BCR_RET;
		else if (isRetGrp && fld == `BCR_F_RETSKIP)
			op = BCR_RETSKIP;
		else if (isRetGrp && fld == `BCR_F_INTERRUPT_RETURN)
			op = BCR_INTERRUPT_RETURN;
		else if (isMisc && fld == `BCR_F_IRQ_ALLOW)
			op = BCR_IRQ_ALLOW;
		else if (isMisc && fld == `BCR_F_IRQ_BLOCK)
			op = BCR_IRQ_BLOCK;
		else if (isMisc && fld == `BCR_F_STOP)
			op = BCR_STOP;
		else if (isMisc && fld == `BCR_F_HALT)
			op = BCR_HALT;
		else if (isMisc && fld == `BCR_F_NOP)
			op = BCR_NOP;
	end
	// Small variant has no page field, larger ones take opcode low bits
	assign dec.op = op;
	assign dec.page = smallRom ? `BCR_PAGE_ZERO : opc[1:0];
	assign dec.addr = instr[10:0];
	assign dec.cond = instr[3:0];
endmodule

// ==== logic/bcr_branch_call_return.sv ====
// Control-flow executor: branches, calls, returns, interrupt enable, standby.
// Assumes one instruction presented per cycle with instrValid; pcNext is the return address.
`timescale 1ns/1ps
`include "bcr_cfg.svh"
module bcr_branch_call_return
	import bcr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic instrValid,
	input wire logic [15:0] instr,
	input wire logic smallRom,
	input wire logic [12:0] pcNext,
	input wire logic [12:0] indirectTargetRegister,
	input wire logic [3:0] interruptSavedStateIn,
	output logic [12:0] pcOut,
	output logic pcLoad,
	output logic skipNext,
	output logic [2:0] stackPointer,
	output logic [12:0] addressStackTop,
	output logic systemCallFlag,
	output logic interruptEnableFlag,
	output logic [3:0] interruptSavedState,
	output logic interruptSavedLoad,
	output logic stopReq,
	output logic haltReq,
	output logic [3:0] standbyCond
);
	bcr_dec_t dec;
	logic [12:0] stack_q [`BCR_STACK_DEPTH];
	logic [3:0] intSave_q [`BCR_STACK_DEPTH];
	logic [2:0] sp_q;
	logic [12:0] pc_q;
	logic pcLoad_q, skip_q, sys_q, ien_q, isl_q, stop_q, halt_q;
	logic [3:0] saved_q, cond_q;

	bcr_decode uDecode
	(
		.instr(instr),
		.smallRom(smallRom),
		.dec(dec)
	);

	function automatic logic [2:0] spStep(input logic [2:0] sp, input logic up);
		spStep = up ? 3'(sp + 3'h1) : 3'(sp - 3'h1);
	endfunction

	// An operation fires only when its word is valid this cycle
	function automatic logic fire(input bcr_dec_t d, input bcr_op_t want, input logic valid);
		fire = valid && (d.op == want);
	endfunction

	// Execute strobes
	// Words that are not control flow leave every strobe low
	wire go = instrValid;
	wire doCall = fire(dec, BCR_CALL, go);
	wire doCallInd = fire(dec, BCR_CALL_IND, go);
	wire doSys = fire(dec, BCR_SYSCALL, go);
	wire doPush = doCall || doCallInd || doSys;
	wire doRet = fire(dec, BCR_RET, go);
	wire doRetSkip = fire(dec, BCR_RETSKIP, go);
	wire doReti = fire(dec, BCR_INTERRUPT_RETURN, go);
	wire doPop = doRet || doRetSkip || doReti;
	wire doJump = fire(dec, BCR_JUMP, go);
	wire doJumpInd = fire(dec, BCR_JUMP_IND, go);

	// Interrupt enable and standby strobes
	wire doIrqAllow = fire(dec, BCR_IRQ_ALLOW, go);
	wire doIrqBlock = fire(dec, BCR_IRQ_BLOCK, go);
	wire doStop = fire(dec, BCR_STOP, go);
	wire doHalt = fire(dec, BCR_HALT, go);
	wire doStandby = doStop || doHalt;
	wire [2:0] spDec = spStep(sp_q, 1'b0);
	wire [2:0] spInc = spStep(sp_q, 1'b1);
	wire [12:0] topVal = stack_q[sp_q];
	wire [3:0] topSaved = intSave_q[sp_q];

	// Target PC selection
	// Priority order is harmless: at most one strobe is high at a time
	wire [12:0] callTgt = {`BCR_PAGE_ZERO, dec.addr};
	wire [12:0] sysTgt = {`BCR_PAGE_ZERO, instr[10:8], `BCR_SYS_MID, dec.cond};
	wire [12:0] jumpTgt = {dec.page, dec.addr};
	wire [12:0] pcD = doCall ? callTgt
		: (doCallInd || doJumpInd) ? indirectTargetRegister
		: doSys ? sysTgt
		: doPop ? topVal
		: doJump ? jumpTgt
		: pc_q;
	wire pcLoadD = doCall || doCallInd || doSys || doPop || doJump || doJumpInd;

	// Stack pointer: pre-decrement on push, post-increment on pop
	// Pointer wraps modulo eight, matching the eight-entry stack
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			sp_q <= `BCR_SP_RST;
		else if (doPush)
			sp_q <= spDec;
		else if (doPop)
			sp_q <= spInc;
	end

	// Address stack and interrupt save stack storage
	// No reset: entries stay unknown until pushed
	// A ninth push overwrites the oldest return address without warning
	always_ff @(posedge clk_sys)
	begin
		if (doPush)
		begin
			stack_q[spDec] <= pcNext;
			intSave_q[spDec] <= interruptSavedStateIn;
		end
	end

	// Program counter and its load strobe
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pc_q <= `BCR_PC_RST;
			pcLoad_q <= 1'b0;
		end
		else
		begin
			pc_q <= pcD;
			pcLoad_q <= pcLoadD;
		end
	end

	// System-call flag is sticky; only reset clears it
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			sys_q <= 1'b0;
		else if (doSys)
			sys_q <= 1'b1;
	end

	// Interrupt enable follows the last allow or block word
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			ien_q <= 1'b0;
		else if (doIrqAllow)
			ien_q <= 1'b1;
		else if (doIrqBlock)
			ien_q <= 1'b0;
	end

	// One-cycle pulses: skip, saved-state load, stop and halt
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			skip_q <= 1'b0;
			isl_q <= 1'b0;
			stop_q <= 1'b0;
			halt_q <= 1'b0;
		end
		else
		begin
			skip_q <= doRetSkip;
			isl_q <= doReti;
			stop_q <= doStop;
			halt_q <= doHalt;
		end
	end

	// Saved interrupt state is taken from the save stack on interrupt return
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			saved_q <= `BCR_SAVED_RST;
		else if (doReti)
			saved_q <= topSaved;
	end

	// Standby condition holds the operand of the last stop or halt
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			cond_q <= `BCR_COND_RST;
		else if (doStandby)
			cond_q <= dec.cond;
	end

	assign pcOut = pc_q;
	assign pcLoad = pcLoad_q;
	assign skipNext = skip_q;
	assign stackPointer = sp_q;
	assign systemCallFlag = sys_q;
	assign interruptEnableFlag = ien_q;
	assign interruptSavedState = saved_q;
	assign interruptSavedLoad = isl_q;
	assign stopReq = stop_q;
	assign haltReq = halt_q;
	assign standbyCond = cond_q;

	// Stack top shown registered; follows the pointer one cycle later
	// Registered so that the output comes straight from a flip-flop
	logic [12:0] top_q;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			top_q <= `BCR_PC_RST;
		else
			top_q <= topVal;
	end
	assign addressStackTop = top_q;
endmodule

// ==== testbench/bcr_properties.sv ====
// Concurrent checks on the control-flow executor ports.
// Assumes a one-cycle answer and a bind by port name.
`timescale 1ns/1ps
module bcr_properties
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic instrValid,
	input wire logic [15:0] instr,
	input wire logic smallRom,
	input wire logic [12:0] indirectTargetRegister,
	input wire logic [12:0] pcOut,
	input wire logic pcLoad,
	input wire logic skipNext,
	input wire logic [2:0] stackPointer,
	input wire logic systemCallFlag,
	input wire logic interruptEnableFlag,
	input wire logic interruptSavedLoad,
	input wire logic stopReq,
	input wire logic [3:0] standbyCond
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// Targets, flags and stack motion one cycle after the word
	a_call_direct:
		assert property (instrValid && instr[15:11] == 5'h1c |=> pcLoad && pcOut == {2'h0, $past(instr[10:0])}
		&& stackPointer == $past(stackPointer) - 3'h1) else $error("direct call wrong");
	a_call_indirect:
		assert property (instrValid && instr == 16'h3850 |=> pcOut == $past(indirectTargetRegister)
		&& stackPointer == $past(stackPointer) - 3'h1) else $error("indirect call wrong");
	a_syscall_entry:
		assert property (instrValid && instr[15:11] == 5'h07 && instr[7:4] == 4'h0 |=> systemCallFlag
		&& pcOut == {2'h0, $past(instr[10:8]), 4'h0, $past(instr[3:0])}) else $error("system call wrong");
	a_return_pop:
		assert property (instrValid && instr == 16'h38e0 |=> pcLoad
		&& stackPointer == $past(stackPointer) + 3'h1) else $error("return wrong");
	a_skip_pulse:
		assert property (skipNext == ($past(instrValid) && $past(instr) == 16'h39e0))
		else $error("skip pulse wrong");
	a_interrupt_return_restore:
		assert property (instrValid && instr == 16'h3ce0 |=> interruptSavedLoad
		&& stackPointer == $past(stackPointer) + 3'h1) else $error("interrupt return wrong");
	a_small_jump:
		assert property (instrValid && smallRom && instr[15:11] == 5'h0c |=> pcLoad
		&& pcOut == {2'h0, $past(instr[10:0])}) else $error("small jump wrong");
	a_paged_jump:
		assert property (instrValid && !smallRom && instr[15:13] == 3'h3 |=> pcLoad
		&& pcOut == $past(instr[12:0])) else $error("paged jump wrong");
	a_irq_enable:
		assert property (instrValid && instr[15:9] == 7'h1c && instr[7:0] == 8'hf0
		|=> interruptEnableFlag == !$past(instr[8])) else $error("enable flag wrong");
	a_stop_cond:
		assert property (instrValid && instr[15:4] == 12'h3af |=> stopReq
		&& standbyCond == $past(instr[3:0])) else $error("stop wrong");
endmodule

// ==== testbench/bcr_branch_call_return_test.sv ====
// Random self-checking bench for the control-flow executor.
// Assumes one word per cycle and the answer one edge later.
`timescale 1ns/1ps
`define CK(a, e) begin numChecks++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: %h exp %h", $time, a, e); end end
module bcr_branch_call_return_test;
	logic clk_sys = 1'h0, resetn = 1'h0, instrValid = 1'h0, smallRom = 1'h0, v;
	logic [15:0] instr = 16'h0;
	logic [12:0] pcNext = 13'h0, indirectTargetRegister = 13'h0, pcOut, addressStackTop, mPc, mTop, stk[8];
	logic [3:0] interruptSavedStateIn = 4'h0, interruptSavedState, standbyCond, mIs, mCond, k, sav[8];
	logic pcLoad, skipNext, systemCallFlag, interruptEnableFlag, interruptSavedLoad, stopReq, haltReq;
	logic [2:0] stackPointer, mSp;
	logic mLd, mSk, mScf, mIe, mIsl, mStp, mHlt;
	logic [31:0] r = 32'h7746;
	int miscompares = 0, numChecks = 0, i;
	bcr_branch_call_return DUT
	(
		.clk_sys(clk_sys), .resetn(resetn), .instrValid(instrValid), .instr(instr), .smallRom(smallRom),
		.pcNext(pcNext), .indirectTargetRegister(indirectTargetRegister),
		.interruptSavedStateIn(interruptSavedStateIn), .pcOut(pcOut), .pcLoad(pcLoad), .skipNext(skipNext),
		.stackPointer(stackPointer), .addressStackTop(addressStackTop), .systemCallFlag(systemCallFlag),
		.interruptEnableFlag(interruptEnableFlag), .interruptSavedState(interruptSavedState),
		.interruptSavedLoad(interruptSavedLoad), .stopReq(stopReq), .haltReq(haltReq), .standbyCond(standbyCond)
	);
	// Free-running system clock
	always #10 clk_sys = ~clk_sys;
	function logic [31:0] nx(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// A jump counts only if the variant has the page that it names
	function logic jumpOk(logic sr, logic [15:0] w);
		return !sr || w[12:11] == 2'h0;
	endfunction
	// Instruction word for each kind; kind b and the default kinds are not control flow
	function logic [15:0] pick(logic [3:0] c, logic [31:0] s);
		case (c)
			4'h0: return {3'h3, s[13:12], s[10:0]};
			4'h1: return {5'h1c, s[10:0]};
			4'h2: return 16'h3850;
			4'h3: return {5'h07, s[10:8], 4'h0, s[3:0]};
			4'h4: return 16'h38e0;
			4'h5: return 16'h39e0;
			4'h6: return 16'h3ce0;
			4'h7: return 16'h38f0;
			4'h8: return 16'h39f0;
			4'h9: return {12'h3af, s[3:0]};
			4'ha: return {12'h3bf, s[3:0]};
			4'hb: return 16'h3cf0;
			4'hc: return 16'h3840;
			default: return {5'h08, s[10:0]};
		endcase
	endfunction
	task giveVerdict;
		$display("checks %0d miscompares %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Nine calls first wrap the stack, then random words follow
	initial
	begin
		{mPc, mSp, mLd, mSk, mScf, mIe, mIs, mIsl, mStp, mHlt, mCond} = 31'h0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'h1;
		for (i = 0; i < 600; i++)
		begin
			@(posedge clk_sys);
			r = nx(r);
			k = (i < 9) ? 4'h1 : r[3:0];
			v = (i < 9) || (|r[6:4]);
			instrValid <= v;
			instr <= pick(k, r);
			smallRom <= r[7];
			pcNext <= r[20:8];
			indirectTargetRegister <= r[31:19];
			interruptSavedStateIn <= r[11:8];
			#1;
			`CK(pcOut, mPc)
			`CK(stackPointer, mSp)
			`CK({pcLoad, skipNext}, {mLd, mSk})
			`CK({systemCallFlag, interruptEnableFlag}, {mScf, mIe})
			`CK({interruptSavedLoad, interruptSavedState}, {mIsl, mIs})
			`CK({stopReq, haltReq, standbyCond}, {mStp, mHlt, mCond})
			if (i > 9)
				`CK(addressStackTop, mTop)
			mTop = stk[mSp];
			{mLd, mSk, mIsl, mStp, mHlt} = 5'h0;
			if (v)
			begin
				if (k inside {4'h1, 4'h2, 4'h3})
				begin
					mSp = mSp - 3'h1;
					stk[mSp] = pcNext;
					sav[mSp] = interruptSavedStateIn;
				end
				case (k)
					4'h0: mPc = jumpOk(smallRom, instr) ? instr[12:0] : mPc;
					4'h1: mPc = {2'h0, instr[10:0]};
					4'h2, 4'hc: mPc = indirectTargetRegister;
					4'h3: mPc = {2'h0, instr[10:8], 4'h0, instr[3:0]};
					4'h4, 4'h5, 4'h6: mPc = stk[mSp];
					default: mPc = mPc;
				endcase
				if (k == 4'h6)
				begin
					mIs = sav[mSp];
					mIsl = 1'h1;
				end
				if (k inside {4'h4, 4'h5, 4'h6})
					mSp = mSp + 3'h1;
				mLd = (k <= 4'h6 || k == 4'hc) && (k != 4'h0 || jumpOk(smallRom, instr));
				mSk = k == 4'h5;
				mScf = mScf | (k == 4'h3);
				mIe = (k == 4'h7) ? 1'h1 : (k == 4'h8) ? 1'h0 : mIe;
				mStp = k == 4'h9;
				mHlt = k == 4'ha;
				mCond = (mStp || mHlt) ? instr[3:0] : mCond;
			end
		end
		giveVerdict();
	end
endmodule
bind bcr_branch_call_return bcr_properties chk
(
	.clk_sys(clk_sys), .resetn(resetn), .instrValid(instrValid), .instr(instr), .smallRom(smallRom),
	.indirectTargetRegister(indirectTargetRegister), .pcOut(pcOut), .pcLoad(pcLoad), .skipNext(skipNext),
	.stackPointer(stackPointer), .systemCallFlag(systemCallFlag), .interruptEnableFlag(interruptEnableFlag),
	.interruptSavedLoad(interruptSavedLoad), .stopReq(stopReq), .standbyCond(standbyCond)
);
